// [hw/supply_reset_supervisor.sv]
// Supply reset supervisor: complementary reset outputs driven from the
// supply comparator and a debounced manual reset, plus an early power-fail
// interrupt pulse from the sense comparator.
// Assumes analog comparators outside give synchronous digital levels.
//
// Contract
// - Supply low asserts both reset outputs
// - Hold reset 130 ms after supply recovers
// - Manual reset active low, debounced, 130 ms
// - Manual hold counts from input release
// - Sense below 1.25 V means early fail
// - Power-fail output low pulse, 200 us minimum
// - Fail must persist 5 us first
// - No interrupt before supply reaches trip
// - Interrupt tied to manual input resets
// - Two opposite-polarity resets move together
// - Stable manual low asserts within 250 ns (here RESET_OUT sets on the third edge, 200 to 300 ns after the fall)
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_map.svh"
module supply_reset_supervisor
  import supervisor_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SUPPLY_LOW,
  input wire logic SENSE_BELOW_TRIP,
  input wire logic MANUAL_RESET_IN_N,
  output logic RESET_OUT,
  output logic RESET_OUT_N,
  output logic PFAIL_INT_N
);
  // ************************************************************
  // Input conditioning
  // ************************************************************
  logic mr_n_filt;
  logic sense_low_filt;

  // Short debounce: a stable low sets RESET_OUT on the third clock edge, 200 to 300 ns after it falls, not always inside the 250 ns limit
  stable_filter
  #(
    .LIMIT(8'(`MR_DEBOUNCE_CYCLES)),
    .INIT(1'b1)
  )
  u_mr_filter
  (
    .clk(CORE_CLK),
    .rst(RST),
    .din(MANUAL_RESET_IN_N),
    .dout(mr_n_filt)
  );

  // SENSE_BELOW_TRIP is the comparator result against the reference
  stable_filter
  #(
    .LIMIT(8'(`PFAIL_FILTER_CYCLES)),
    .INIT(1'b0)
  )
  u_sense_filter
  (
    .clk(CORE_CLK),
    .rst(RST),
    .din(SENSE_BELOW_TRIP),
    .dout(sense_low_filt)
  );

  // ************************************************************
  // Reset sequencer
  // ************************************************************
  rst_state_t state;
  rst_state_t next_state;
  logic [`CNT_W-1:0] cnt;
  logic [`CNT_W-1:0] next_cnt;
  logic next_reset;
  logic hold_cause;

  // Either cause keeps the sequencer parked; timing restarts on release
  assign hold_cause = SUPPLY_LOW | ~mr_n_filt;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      RS_HOLD:
      begin
        next_cnt = '0;
        if (!hold_cause)
        begin
          next_state = RS_TIMING;
        end
      end
      RS_TIMING:
      begin
        if (hold_cause)
        begin
          next_state = RS_HOLD;
          next_cnt = '0;
        end
        else if (cnt + 21'h000001 >= 21'(`RESET_HOLD_CYCLES))
        begin
          next_state = RS_RUN;
        end
        else
        begin
          next_cnt = cnt + 21'h000001;
        end
      end
      RS_RUN:
      begin
        if (hold_cause)
        begin
          next_state = RS_HOLD;
          next_cnt = '0;
        end
      end
      default:
      begin
        next_state = RS_HOLD;
        next_cnt = '0;
      end
    endcase
    next_reset = (next_state != RS_RUN);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state <= RS_HOLD;
      cnt <= '0;
      RESET_OUT <= 1'b1;
      RESET_OUT_N <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      RESET_OUT <= next_reset;
      RESET_OUT_N <= ~next_reset;
    end
  end

  // ************************************************************
  // Early power-fail interrupt
  // ************************************************************
  pfail_pulser u_pfail
  (
    .clk(CORE_CLK),
    .rst(RST),
    .sense_low(sense_low_filt),
    .supply_ok(~SUPPLY_LOW),
    .pfail_n(PFAIL_INT_N)
  );
endmodule
`default_nettype wire

// [hw/supervisor_map.svh]
// Timing constants, counter widths and the sense reference for the supply reset supervisor.
// Assumes a 10 MHz core clock (100 ns period).
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

`define CLK_PERIOD_NS 100
// Reset hold time, ms
`define RESET_HOLD_MS 130
`define RESET_HOLD_CYCLES ((`RESET_HOLD_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Power-fail pulse minimum width, us
`define PFAIL_PULSE_US 200
`define PFAIL_PULSE_CYCLES ((`PFAIL_PULSE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Power-fail filter time, us
`define PFAIL_FILTER_US 5
`define PFAIL_FILTER_CYCLES ((`PFAIL_FILTER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Manual reset debounce: stable-low time, ns (must fit inside the 250 ns assert limit)
`define MR_DEBOUNCE_NS 100
`define MR_DEBOUNCE_CYCLES ((`MR_DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Sense reference, millivolts (the analog comparator sits outside)
`define SENSE_REF_MV 1250
`define CNT_W 21
`define FILT_W 8

`endif

// [hw/supervisor_pkg.sv]
// Types shared by the supply reset supervisor files.
// Assumes nothing beyond the map header.
package supervisor_pkg;
  typedef enum logic [1:0] {
    RS_HOLD = 2'b00,
    RS_TIMING = 2'b01,
    RS_RUN = 2'b10
  } rst_state_t;
  typedef enum logic [1:0] {
    PF_IDLE = 2'b00,
    PF_PULSE = 2'b01,
    PF_WAIT = 2'b10
  } pf_state_t;
endpackage

// [hw/stable_filter.sv]
// Stable-level filter: output follows the input only after it has held
// one value for LIMIT+1 consecutive cycles.
// Assumes the input is synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_map.svh"
module stable_filter
#(
  parameter logic [`FILT_W-1:0] LIMIT = 8'h01,
  parameter logic INIT = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic [`FILT_W-1:0] cnt;
  logic [`FILT_W-1:0] next_cnt;
  logic next_dout;

  always_comb
  begin
    next_cnt = cnt;
    next_dout = dout;
    if (din == dout)
    begin
      next_cnt = '0;
    end
    // A change seen on one edge only is a glitch and is dropped
    else if (cnt >= LIMIT)
    begin
      next_dout = din;
      next_cnt = '0;
    end
    else
    begin
      next_cnt = cnt + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= '0;
      dout <= INIT;
    end
    else
    begin
      cnt <= next_cnt;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

// [hw/pfail_pulser.sv]
// Power-fail interrupt pulse generator: filtered low sense starts one
// minimum-width active-low pulse, armed only once the supply is good.
// Assumes filtered, synchronous inputs.
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_map.svh"
module pfail_pulser
  import supervisor_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sense_low,
  input wire logic supply_ok,
  output logic pfail_n
);
  pf_state_t state;
  pf_state_t next_state;
  logic [`CNT_W-1:0] cnt;
  logic [`CNT_W-1:0] next_cnt;
  logic armed;
  logic next_armed;
  logic next_pfail_n;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_armed = armed | supply_ok;
    next_pfail_n = 1'b1;
    case (state)
      PF_IDLE:
      begin
        // Power-up lows are ignored until the supply reached its trip level
        if (sense_low && armed)
        begin
          next_state = PF_PULSE;
          next_cnt = '0;
          next_pfail_n = 1'b0;
        end
      end
      PF_PULSE:
      begin
        next_pfail_n = 1'b0;
        next_cnt = cnt + 21'h000001;
        if (cnt + 21'h000001 >= 21'(`PFAIL_PULSE_CYCLES))
        begin
          next_state = PF_WAIT;
          next_pfail_n = 1'b1;
        end
      end
      PF_WAIT:
      begin
        // One pulse per event: rearm only once the sense recovers
        if (!sense_low)
        begin
          next_state = PF_IDLE;
        end
      end
      default:
      begin
        next_state = PF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= PF_IDLE;
      cnt <= '0;
      armed <= 1'b0;
      pfail_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      armed <= next_armed;
      pfail_n <= next_pfail_n;
    end
  end
endmodule
`default_nettype wire

// [testbench/supervisor_sva.sv]
// Port checker for the supply reset supervisor.
// Assumes one clock domain and a synchronous high reset.
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_map.svh"
module supervisor_sva
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SUPPLY_LOW,
  input wire logic SENSE_BELOW_TRIP,
  input wire logic MANUAL_RESET_IN_N,
  input wire logic RESET_OUT,
  input wire logic RESET_OUT_N,
  input wire logic PFAIL_INT_N
);
  logic [15:0] lo_cnt, next_lo_cnt, hi_cnt, next_hi_cnt;
  logic armed, next_armed;
  logic [20:0] ok_cnt, next_ok_cnt;
  always_comb
  begin
    // Cycles since the last reset cause went away, saturating
    next_ok_cnt = (RST || SUPPLY_LOW || !MANUAL_RESET_IN_N) ? 21'h0 : ok_cnt + {20'h0, ok_cnt != 21'h1fffff};
    next_lo_cnt = PFAIL_INT_N ? 16'h0 : lo_cnt + 16'h1;
    next_hi_cnt = SENSE_BELOW_TRIP ? hi_cnt + 16'h1 : 16'h0;
    next_armed = !RST && (armed || !SUPPLY_LOW);
  end
  always_ff @(posedge CORE_CLK)
  begin
    lo_cnt <= next_lo_cnt;
    hi_cnt <= next_hi_cnt;
    armed <= next_armed;
    ok_cnt <= next_ok_cnt;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence s_press;
    !MANUAL_RESET_IN_N [*2];
  endsequence
  a_reset_vals: assert property (disable iff (1'b0) RST |=> RESET_OUT && PFAIL_INT_N)
    else $error("outputs wrong after reset");
  a_pair_move: assert property (RESET_OUT_N == !RESET_OUT)
    else $error("reset outputs not complementary");
  a_supply_low: assert property (SUPPLY_LOW |=> RESET_OUT)
    else $error("supply low without reset");
  a_press_fast: assert property (s_press |-> ##[0:2] RESET_OUT)
    else $error("manual press too slow");
  a_pulse_min: assert property ($fell(PFAIL_INT_N) |=> !PFAIL_INT_N [*8])
    else $error("power-fail pulse too short");
  a_pulse_width: assert property ($rose(PFAIL_INT_N) |-> lo_cnt == 16'h7d0)
    else $error("power-fail pulse width wrong");
  a_filter_time: assert property ($fell(PFAIL_INT_N) |-> $past(hi_cnt) >= 16'h30)
    else $error("power-fail without filter");
  a_arm_first: assert property ($fell(PFAIL_INT_N) |-> $past(armed))
    else $error("power-fail before supply good");
  a_hold_time: assert property ($fell(RESET_OUT) |-> ok_cnt >= 21'(`RESET_HOLD_CYCLES))
    else $error("reset released before hold time");
endmodule
bind supply_reset_supervisor supervisor_sva chk (.CORE_CLK(CORE_CLK), .RST(RST), .SUPPLY_LOW(SUPPLY_LOW),
  .SENSE_BELOW_TRIP(SENSE_BELOW_TRIP), .MANUAL_RESET_IN_N(MANUAL_RESET_IN_N),
  .RESET_OUT(RESET_OUT), .RESET_OUT_N(RESET_OUT_N), .PFAIL_INT_N(PFAIL_INT_N));
`default_nettype wire

// [testbench/sys_partner.sv]
// System wiring around the supervisor: button or interrupt to manual input.
// Assumes the bench drives button and strap levels.
`timescale 1ns/1ns
`default_nettype none
module sys_partner
(
  input wire logic button_n,
  input wire logic tie,
  input wire logic pfail_n,
  output logic manual_n
);
  // Strap lets the interrupt pulse act as a press
  assign manual_n = tie ? pfail_n : button_n;
endmodule
`default_nettype wire

// [testbench/supply_reset_supervisor_test.sv]
// Self-checking bench for the supply reset supervisor.
// Assumes the 1300000-cycle hold never ends within this run.
`timescale 1ns/1ns
`default_nettype none
module supply_reset_supervisor_test;
  logic clk = 0, rst = 1, low = 1, sense = 0, btn = 1, tie = 0, seen = 0;
  wire logic man_n, rout, rout_n, pf_n;
  int miscompares = 0, check_count = 0;
  initial forever #50 clk = ~clk;
  always @(negedge clk) if (pf_n !== 1'b1) seen = 1;
  supply_reset_supervisor dut (.CORE_CLK(clk), .RST(rst), .SUPPLY_LOW(low), .SENSE_BELOW_TRIP(sense),
    .MANUAL_RESET_IN_N(man_n), .RESET_OUT(rout), .RESET_OUT_N(rout_n), .PFAIL_INT_N(pf_n));
  sys_partner sys (.button_n(btn), .tie(tie), .pfail_n(pf_n), .manual_n(man_n));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic quiet(input int n);
    seen = 0;
    sense = 1;
    cyc(n);
    sense = 0;
    cyc(90);
    chk(seen, 1'b0);
  endtask
  // Returns cycles waited for the pulse and its low width
  task automatic pulse(output int w, output int m);
    w = 0;
    m = 0;
    sense = 1;
    while (pf_n === 1'b1 && w < 90)
    begin
      cyc(1);
      w++;
    end
    if (tie)
    begin
      cyc(3);
      m = 3;
      chk(man_n, 0);
      chk({rout, rout_n}, 2'h2);
    end
    while (pf_n === 1'b0 && m < 3000)
    begin
      cyc(1);
      m++;
    end
    sense = 0;
    // Filtered sense must fall back before the next event is armed
    cyc(60);
  endtask
  task automatic reset_release;
    cyc(5);
    rst = 0;
    cyc(1);
    chk({rout, rout_n, pf_n}, 3'h5);
  endtask
  // Supply still low: sense lows must not start a pulse
  task automatic power_up_block;
    quiet(120);
    low = 0;
    cyc(2);
  endtask
  task automatic short_sense;
    quiet(30);
  endtask
  task automatic pfail_event;
    int w;
    int m;
    pulse(w, m);
    chk(w >= 48 && w < 60, 1);
    chk(m, 16'h7d0);
  endtask
  task automatic tied_event;
    int w;
    int m;
    tie = 1;
    pulse(w, m);
    chk(m, 16'h7d0);
    tie = 0;
  endtask
  task automatic manual_glitch;
    btn = 0;
    cyc(1);
    btn = 1;
    cyc(3);
    chk({rout, rout_n}, 2'h2);
  endtask
  task automatic supply_drop;
    low = 1;
    cyc(2);
    chk({rout, rout_n}, 2'h2);
  endtask
  // Reset again with the supply low: the power-fail arm must drop
  task automatic mid_run_reset;
    rst = 1;
    cyc(2);
    rst = 0;
    cyc(1);
    chk({rout, rout_n, pf_n}, 3'h5);
    quiet(120);
  endtask
  // ****
  // Scenarios
  // ****
  initial
  begin
    reset_release();
    power_up_block();
    short_sense();
    pfail_event();
    tied_event();
    manual_glitch();
    supply_drop();
    mid_run_reset();
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
